/* File: inc/sfc_pkg.sv */
// Purpose: constants and types shared by the serial flash controller
// Assumes: 25 MHz clk_i, registers are 32-bit words on Avalon-MM
// Notes: offsets are byte addresses; the state is one packed struct
package sfc_pkg;
    localparam logic [5:0] CR_OFS = 6'h00;
    localparam logic [5:0] DCR_OFS = 6'h04;
    localparam logic [5:0] SR_OFS = 6'h08;
    localparam logic [5:0] DLR_OFS = 6'h0C;
    localparam logic [5:0] CCR_OFS = 6'h10;
    localparam logic [5:0] AR_OFS = 6'h14;
    localparam logic [5:0] ABR_OFS = 6'h18;
    localparam logic [5:0] DR_OFS = 6'h1C;
    localparam logic [5:0] PSMK_OFS = 6'h20;
    localparam logic [5:0] PSMA_OFS = 6'h24;
    localparam logic [5:0] PIR_OFS = 6'h28;
    // control_reg bits
    localparam int CR_EN = 0;
    localparam int CR_ASTOP = 1;
    localparam int CR_PFEN = 2;
    localparam int CR_DUAL = 3;
    localparam int CR_DMAEN = 4;
    localparam int CR_MIE = 5;
    localparam int CR_W = 6;
    // status bits
    localparam int SR_MATCH = 1;
    // comm_config_reg field positions
    localparam int CC_OPC = 0;
    localparam int CC_IMODE = 8;
    localparam int CC_AMODE = 10;
    localparam int CC_ASIZE = 12;
    localparam int CC_ABMODE = 14;
    localparam int CC_DUMMY = 16;
    localparam int CC_DMODE = 24;
    localparam int CC_FMODE = 26;
    // device_config_reg field positions
    localparam int DC_FSIZE = 0;
    localparam int DC_DIV = 8;
    localparam int DC_W = 13;
    localparam logic [1:0] FM_IWR = 2'h0;
    localparam logic [1:0] FM_IRD = 2'h1;
    localparam logic [1:0] FM_POLL = 2'h2;
    localparam logic [1:0] FM_MMAP = 2'h3;
    // top nibble of the mapped window 0x7000_0000, 256 MB span
    localparam logic [3:0] MM_BASE = 4'h7;
    localparam logic [5:0] FIFO_FULL = 6'h20;
    localparam logic [31:0] POLL_MAX = 32'h0000_0004;
    localparam logic [31:0] MM_LEN = 32'h0000_0004;
    // half period of the flash clock is HALF_MIN + 1 + divider cycles
    localparam logic [4:0] HALF_MIN = 5'h03;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01, ST_INSTR = 7'h02, ST_ADDR = 7'h04,
        ST_ALT = 7'h08, ST_DUMMY = 7'h10, ST_DATA = 7'h20,
        ST_GAP = 7'h40
    } st_e;
    typedef struct packed {
        logic sck;
        logic flash_select_n;
        logic [7:0] line_out;
        logic [7:0] line_oe;
    } pins_s;
    typedef struct packed {
        st_e st;
        logic [CR_W-1:0] cr;
        logic [DC_W-1:0] dcr;
        logic [31:0] dlr;
        logic [31:0] ccr;
        logic [31:0] ar;
        logic [7:0] abr;
        logic [31:0] mk;
        logic [31:0] ma;
        logic [15:0] pir;
        logic match;
        logic halt;
        logic [31:0][7:0] mem;
        logic [4:0] wp;
        logic [4:0] rp;
        logic [5:0] cnt;
        logic [4:0] div;
        logic [7:0] sh;
        logic [3:0] bl;
        logic [1:0] bi;
        logic [31:0] dleft;
        logic [1:0] dk;
        logic [4:0] dum;
        logic need;
        logic [31:0] fa;
        logic [31:0] stat;
        logic [15:0] gap;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [7:0] s3;
        logic [7:0] lin;
        logic [31:0] mw;
        logic [31:0] mtag;
        logic mval;
        logic pfq;
        logic mmf;
        logic wr;
        logic [31:0] rd;
        logic mwr;
        logic [31:0] mrd;
        pins_s pin;
        logic dma;
        logic irq;
    } state_s;
endpackage

/* File: design/serial_flash_controller.sv */
// Purpose: serial flash controller, indirect, polling and mapped reads
// Assumes: single clock clk_i, flash lines sampled through three flops
module serial_flash_controller (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [5:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic [31:0] mm_address_i,
    input wire logic mm_read_i,
    output logic [31:0] mm_readdata_o,
    output logic mm_waitrequest_o,
    input wire logic [7:0] flash_line_i,
    output sfc_pkg::pins_s flash_o,
    output logic dma_req_o,
    output logic match_irq_o
);
    import sfc_pkg::*;

    state_s q;
    state_s next_q;

    function automatic logic [1:0] phase_mode(input st_e st,
                                             input logic [31:0] c);
        logic [1:0] r;
        r = 2'h0;
        case (st)
            ST_INSTR: r = c[CC_IMODE +: 2];
            ST_ADDR: r = c[CC_AMODE +: 2];
            ST_ALT: r = c[CC_ABMODE +: 2];
            ST_DATA: r = c[CC_DMODE +: 2];
            default: r = 2'h0;
        endcase
        return r;
    endfunction

    function automatic logic [2:0] lanes(input logic [1:0] m);
        logic [2:0] r;
        case (m)
            2'h2: r = 3'h2;
            2'h3: r = 3'h4;
            default: r = 3'h1;
        endcase
        return r;
    endfunction

    // later checks win, so the earliest phase present is returned
    function automatic st_e after(input st_e cur, input logic [31:0] c,
                                  input logic dat);
        st_e r;
        logic early;
        r = ST_IDLE;
        early = cur inside {ST_IDLE, ST_INSTR, ST_ADDR, ST_ALT};
        if (dat && c[CC_DMODE +: 2] != 2'h0 && cur != ST_DATA) begin
            r = ST_DATA;
        end
        if (c[CC_DUMMY +: 5] != 5'h00 && early) begin
            r = ST_DUMMY;
        end
        if (c[CC_ABMODE +: 2] != 2'h0 && early && cur != ST_ALT) begin
            r = ST_ALT;
        end
        if (c[CC_AMODE +: 2] != 2'h0 && cur inside {ST_IDLE, ST_INSTR}) begin
            r = ST_ADDR;
        end
        if (c[CC_IMODE +: 2] != 2'h0 && cur == ST_IDLE) begin
            r = ST_INSTR;
        end
        return r;
    endfunction

    function automatic logic [7:0] tx_lines(input logic [7:0] sh,
                                            input logic [2:0] w,
                                            input logic d);
        logic [7:0] r;
        case (w)
            3'h1: r = {3'h0, d ? sh[6] : sh[7], 3'h0, sh[7]};
            3'h2: r = {2'h0, d ? sh[5:4] : sh[7:6], 2'h0, sh[7:6]};
            default: r = {d ? sh[3:0] : sh[7:4], sh[7:4]};
        endcase
        return r;
    endfunction

    function automatic logic [7:0] rx_bits(input logic [7:0] l,
                                           input logic [2:0] w,
                                           input logic d);
        logic [7:0] r;
        case (w)
            3'h1: r = d ? {6'h00, l[1], l[5]} : {7'h00, l[1]};
            3'h2: r = d ? {4'h0, l[1:0], l[5:4]} : {6'h00, l[1:0]};
            default: r = d ? {l[3:0], l[7:4]} : {4'h0, l[3:0]};
        endcase
        return r;
    endfunction

    always_comb begin
        logic req;
        logic acc;
        logic push;
        logic pop;
        logic enter;
        logic go;
        logic en;
        logic rd_dir;
        logic dual_d;
        logic mok;
        logic mhit;
        logic mmiss;
        logic pmatch;
        logic drive;
        logic [1:0] fm;
        logic [1:0] nm;
        logic [2:0] w;
        logic [2:0] nw;
        logic [3:0] nb;
        logic [4:0] rl;
        logic [5:0] fsz;
        logic [7:0] pd;
        logic [7:0] bits;
        logic [7:0] om;
        logic [31:0] fam;
        st_e tgt;
        next_q = q;
        push = 1'b0;
        pop = 1'b0;
        enter = 1'b0;
        go = 1'b0;
        pd = 8'h00;
        tgt = ST_IDLE;
        fm = q.ccr[CC_FMODE +: 2];
        en = q.cr[CR_EN];
        rd_dir = fm != FM_IWR;
        dual_d = q.cr[CR_DUAL] && q.st == ST_DATA;
        w = lanes(phase_mode(q.st, q.ccr));
        nb = {1'b0, w} << dual_d;
        bits = rx_bits(q.lin, w, dual_d);
        rl = 5'(HALF_MIN + {1'b0, q.dcr[DC_DIV +: 4]});
        fsz = {1'b0, q.dcr[DC_FSIZE +: 5]} + 6'h01;
        fam = 32'h0000_0000;
        // a line change counts only once two stages agree
        next_q.s1 = flash_line_i;
        next_q.s2 = q.s1;
        next_q.s3 = q.s2;
        if (q.s2 == q.s3) begin
            next_q.lin = q.s3;
        end

        // register slave: one wait cycle, then the answer
        req = avs_read_i || avs_write_i;
        acc = req && !q.wr;
        next_q.wr = !(req && q.wr);
        if (req && q.wr) begin
            case (avs_address_i)
                CR_OFS: next_q.rd = 32'(q.cr);
                DCR_OFS: next_q.rd = 32'(q.dcr);
                SR_OFS: next_q.rd = {18'h0_0000, q.cnt, 6'h00, q.match,
                                     q.st != ST_IDLE};
                DLR_OFS: next_q.rd = q.dlr;
                CCR_OFS: next_q.rd = q.ccr;
                AR_OFS: next_q.rd = q.ar;
                ABR_OFS: next_q.rd = 32'(q.abr);
                DR_OFS: next_q.rd = fm == FM_POLL ? q.stat
                                                  : 32'(q.mem[q.rp]);
                PSMK_OFS: next_q.rd = q.mk;
                PSMA_OFS: next_q.rd = q.ma;
                PIR_OFS: next_q.rd = 32'(q.pir);
                default: next_q.rd = 32'h0000_0000;
            endcase
        end
        if (acc && avs_write_i) begin
            case (avs_address_i)
                CR_OFS: begin
                    next_q.cr = avs_writedata_i[CR_W-1:0];
                    next_q.halt = 1'b0;
                end
                DCR_OFS: next_q.dcr = avs_writedata_i[DC_W-1:0];
                SR_OFS: begin
                    if (avs_writedata_i[SR_MATCH]) begin
                        next_q.match = 1'b0;
                    end
                end
                DLR_OFS: next_q.dlr = avs_writedata_i;
                CCR_OFS: begin
                    next_q.ccr = avs_writedata_i;
                    next_q.halt = 1'b0;
                end
                AR_OFS: begin
                    next_q.ar = avs_writedata_i;
                    go = en && !fm[1] && q.st == ST_IDLE;
                end
                ABR_OFS: next_q.abr = avs_writedata_i[7:0];
                DR_OFS: begin
                    if (fm == FM_IWR && q.cnt != FIFO_FULL) begin
                        push = 1'b1;
                        pd = avs_writedata_i[7:0];
                    end
                end
                PSMK_OFS: next_q.mk = avs_writedata_i;
                PSMA_OFS: next_q.ma = avs_writedata_i;
                PIR_OFS: next_q.pir = avs_writedata_i[15:0];
                default: ;
            endcase
        end
        if (acc && avs_read_i && avs_address_i == DR_OFS &&
            fm == FM_IRD && q.cnt != 6'h00) begin
            pop = 1'b1;
        end

        // mapped read port; nothing in it can write the flash
        mok = en && fm == FM_MMAP && mm_address_i[31:28] == MM_BASE;
        mhit = q.mval && q.mtag == {4'h0, mm_address_i[27:2], 2'h0};
        mmiss = mm_read_i && q.mwr && mok && !mhit;
        next_q.mwr = !(mm_read_i && q.mwr && (!mok || mhit));
        if (mm_read_i && q.mwr && !mok) begin
            next_q.mrd = 32'h0000_0000;
        end else if (mm_read_i && q.mwr && mhit) begin
            next_q.mrd = q.mw;
            next_q.pfq = q.cr[CR_PFEN];
        end

        // frame start
        if (q.st == ST_IDLE && en) begin
            if (go) begin
                next_q.fa = avs_writedata_i;
                next_q.dleft = q.dlr;
                next_q.mmf = 1'b0;
            end else if (fm == FM_POLL && !q.halt) begin
                go = 1'b1;
                next_q.fa = q.ar;
                next_q.dleft = q.dlr > POLL_MAX ? POLL_MAX : q.dlr;
                next_q.mmf = 1'b0;
            end else if (fm == FM_MMAP && (mmiss || q.pfq)) begin
                go = 1'b1;
                next_q.fa = mmiss ? {4'h0, mm_address_i[27:2], 2'h0}
                                  : {4'h0, 28'(q.mtag + 32'h0000_0004)};
                next_q.dleft = MM_LEN;
                next_q.mmf = 1'b1;
                next_q.mval = 1'b0;
                next_q.pfq = 1'b0;
            end
            if (go) begin
                next_q.pin.flash_select_n = 1'b0;
                next_q.pin.sck = 1'b0;
                next_q.div = rl;
                enter = 1'b1;
                tgt = after(ST_IDLE, q.ccr, next_q.dleft != 32'h0000_0000);
            end
        end
        // addresses wrap at the programmed flash size
        fam = next_q.fa & ~(32'hFFFF_FFFF << fsz);

        if (q.st == ST_GAP) begin
            if (!en || fm != FM_POLL || q.gap == 16'h0000) begin
                next_q.st = ST_IDLE;
            end else begin
                next_q.gap = q.gap - 16'h0001;
            end
        end else if (q.st != ST_IDLE && !en) begin
            next_q.st = ST_IDLE;
            next_q.pin.flash_select_n = 1'b1;
            next_q.pin.sck = 1'b0;
            next_q.need = 1'b0;
        end else if (q.st != ST_IDLE && q.need) begin
            // next write byte is fetched with the clock held low
            if (q.cnt != 6'h00) begin
                pop = 1'b1;
                next_q.sh = q.mem[q.rp];
                next_q.need = 1'b0;
                next_q.div = rl;
            end
        end else if (q.st != ST_IDLE && q.div != 5'h00) begin
            next_q.div = q.div - 5'h01;
        end else if (q.st != ST_IDLE && !q.pin.sck) begin
            // a read byte starts only when the FIFO can take it
            if (!(q.st == ST_DATA && !fm[1] && rd_dir &&
                  q.bl == 4'h8 && q.cnt == FIFO_FULL)) begin
                next_q.pin.sck = 1'b1;
                next_q.div = rl;
            end
        end else if (q.st != ST_IDLE) begin
            next_q.pin.sck = 1'b0;
            next_q.div = rl;
            next_q.sh = 8'((q.sh << nb) | bits);
            next_q.bl = q.bl - nb;
            if (q.st == ST_DUMMY) begin
                next_q.dum = q.dum - 5'h01;
                if (q.dum == 5'h01) begin
                    enter = 1'b1;
                    tgt = after(q.st, q.ccr, q.dleft != 32'h0000_0000);
                end
            end else if (next_q.bl == 4'h0) begin
                case (q.st)
                    ST_ADDR: begin
                        if (q.bi == 2'h0) begin
                            enter = 1'b1;
                            tgt = after(q.st, q.ccr,
                                        q.dleft != 32'h0000_0000);
                        end else begin
                            next_q.bi = q.bi - 2'h1;
                            next_q.sh = fam[{q.bi - 2'h1, 3'h0} +: 8];
                            next_q.bl = 4'h8;
                        end
                    end
                    ST_DATA: begin
                        if (rd_dir && fm[1]) begin
                            next_q.stat[{q.dk, 3'h0} +: 8] = next_q.sh;
                        end else if (rd_dir) begin
                            push = 1'b1;
                            pd = next_q.sh;
                        end
                        next_q.dk = q.dk + 2'h1;
                        next_q.dleft = q.dleft - 32'h0000_0001;
                        if (q.dleft == 32'h0000_0001) begin
                            enter = 1'b1;
                        end else begin
                            next_q.bl = 4'h8;
                            next_q.sh = 8'h00;
                            next_q.need = !rd_dir;
                        end
                    end
                    default: begin
                        enter = 1'b1;
                        tgt = after(q.st, q.ccr, q.dleft != 32'h0000_0000);
                    end
                endcase
            end
        end

        // phase entry
        pmatch = ((next_q.stat ^ q.ma) & q.mk) == 32'h0000_0000;
        if (enter) begin
            next_q.st = tgt;
            next_q.bl = 4'h8;
            case (tgt)
                ST_INSTR: next_q.sh = q.ccr[CC_OPC +: 8];
                ST_ADDR: begin
                    next_q.bi = q.ccr[CC_ASIZE +: 2];
                    next_q.sh = fam[{q.ccr[CC_ASIZE +: 2], 3'h0} +: 8];
                end
                ST_ALT: next_q.sh = q.abr;
                ST_DUMMY: next_q.dum = q.ccr[CC_DUMMY +: 5];
                ST_DATA: begin
                    next_q.sh = 8'h00;
                    next_q.dk = 2'h0;
                    next_q.need = !rd_dir;
                end
                ST_IDLE: begin
                    next_q.pin.flash_select_n = 1'b1;
                    next_q.pin.sck = 1'b0;
                    if (fm == FM_POLL) begin
                        if (pmatch) begin
                            next_q.match = 1'b1;
                        end
                        if (pmatch && q.cr[CR_ASTOP]) begin
                            next_q.halt = 1'b1;
                        end else begin
                            next_q.st = ST_GAP;
                            next_q.gap = q.pir;
                        end
                    end
                    if (q.mmf || next_q.mmf) begin
                        next_q.mval = 1'b1;
                        next_q.mtag = next_q.fa;
                        next_q.mw = next_q.stat;
                        next_q.mmf = 1'b0;
                    end
                end
                default: ;
            endcase
        end

        // pins follow the shift register of the phase being sent
        nm = phase_mode(next_q.st, q.ccr);
        nw = lanes(nm);
        drive = !next_q.pin.flash_select_n && nm != 2'h0 &&
                !(next_q.st == ST_DATA && rd_dir);
        om = q.cr[CR_DUAL] ? 8'hFF : 8'h0F;
        case (nw)
            3'h1: om = om & 8'h11;
            3'h2: om = om & 8'h33;
            default: ;
        endcase
        next_q.pin.line_out = drive ? tx_lines(next_q.sh, nw,
            q.cr[CR_DUAL] && next_q.st == ST_DATA) : 8'h00;
        next_q.pin.line_oe = drive ? om : 8'h00;

        // shared FIFO, one push and one pop per cycle at most
        if (push) begin
            next_q.mem[q.wp] = pd;
            next_q.wp = q.wp + 5'h01;
        end
        if (pop) begin
            next_q.rp = q.rp + 5'h01;
        end
        next_q.cnt = 6'(q.cnt + {5'h00, push} - {5'h00, pop});
        next_q.dma = en && q.cr[CR_DMAEN] && !fm[1] &&
                     next_q.st != ST_IDLE &&
                     (rd_dir ? next_q.cnt != 6'h00 : next_q.cnt != FIFO_FULL);
        next_q.irq = next_q.match && q.cr[CR_MIE];
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.wr <= 1'b1;
            q.mwr <= 1'b1;
            q.pin.flash_select_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign avs_readdata_o = q.rd;
    assign avs_waitrequest_o = q.wr;
    assign mm_readdata_o = q.mrd;
    assign mm_waitrequest_o = q.mwr;
    assign flash_o = q.pin;
    assign dma_req_o = q.dma;
    assign match_irq_o = q.irq;
endmodule // serial_flash_controller

/* File: verif/serial_flash_controller_sva.sv */
// Purpose: port checker for the serial flash controller
// Assumes: the clock divider stays at zero
// Notes: enable, irq enable and mode are tracked from accepted writes
module serial_flash_controller_sva (
    input logic clk_i,
    input logic arst_n_i,
    input logic [5:0] avs_address_i,
    input logic avs_read_i,
    input logic avs_write_i,
    input logic [31:0] avs_writedata_i,
    input logic [31:0] avs_readdata_o,
    input logic avs_waitrequest_o,
    input logic [31:0] mm_address_i,
    input logic mm_read_i,
    input logic [31:0] mm_readdata_o,
    input logic mm_waitrequest_o,
    input logic [7:0] flash_line_i,
    input sfc_pkg::pins_s flash_o,
    input logic dma_req_o,
    input logic match_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import sfc_pkg::*;
    logic en, mie;
    logic [1:0] fm;
    wire acc_w = avs_write_i && !avs_waitrequest_o;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            en <= 1'b0;
            mie <= 1'b0;
            fm <= 2'h0;
        end else if (acc_w && avs_address_i == CR_OFS) begin
            en <= avs_writedata_i[CR_EN];
            mie <= avs_writedata_i[CR_MIE];
        end else if (acc_w && avs_address_i == CCR_OFS) begin
            fm <= avs_writedata_i[CC_FMODE+:2];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_req;
        (avs_read_i || avs_write_i) && avs_waitrequest_o;
    endsequence
    sequence s_ar_go;
        acc_w && avs_address_i == AR_OFS;
    endsequence
    property p_wait_one;
        s_req |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
    endproperty
    property p_ar_start;
        s_ar_go ##0 (en && !fm[1] && flash_o.flash_select_n)
            |=> !flash_o.flash_select_n;
    endproperty
    property p_off;
        !en && flash_o.flash_select_n |=> flash_o.flash_select_n;
    endproperty
    property p_dma;
        dma_req_o |-> !fm[1] || !$past(fm[1]);
    endproperty
    property p_irq;
        match_irq_o |-> mie || $past(mie);
    endproperty
    property p_mm_out;
        mm_read_i && mm_waitrequest_o && mm_address_i[31:28] != MM_BASE
            |=> !mm_waitrequest_o && mm_readdata_o == 32'h0000_0000;
    endproperty
    property p_sck_half;
        $rose(flash_o.sck) |-> (flash_o.sck || !en)[*4];
    endproperty
    property p_sck_quiet;
        flash_o.flash_select_n |-> !flash_o.sck;
    endproperty
    property p_oe_frame;
        |flash_o.line_oe |-> !flash_o.flash_select_n;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus wait");
    a_ar_start: assert property (p_ar_start) else $error("no start");
    a_off: assert property (p_off) else $error("frame off");
    a_dma: assert property (p_dma) else $error("dma mode");
    a_irq: assert property (p_irq) else $error("irq mask");
    a_mm_out: assert property (p_mm_out) else $error("mm window");
    a_sck_half: assert property (p_sck_half) else $error("sck half");
    a_sck_quiet: assert property (p_sck_quiet) else $error("sck idle");
    a_oe_frame: assert property (p_oe_frame) else $error("oe idle");
endmodule // serial_flash_controller_sva

bind serial_flash_controller serial_flash_controller_sva i_sva (
    .clk_i(clk_i), .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .mm_address_i(mm_address_i),
    .mm_read_i(mm_read_i), .mm_readdata_o(mm_readdata_o),
    .mm_waitrequest_o(mm_waitrequest_o), .flash_line_i(flash_line_i),
    .flash_o(flash_o), .dma_req_o(dma_req_o), .match_irq_o(match_irq_o));

/* File: verif/sfc_flash_model.sv */
// Purpose: behavioural flash answering one byte on line 1
// Assumes: one-line opcode, no address phase
// Notes: released lines show the inverse of their last value
module sfc_flash_model (
    input sfc_pkg::pins_s pins_i,
    input logic [7:0] data_i,
    output logic [7:0] line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int n = 0;
    initial line_o = 8'h00;
    always @(negedge pins_i.flash_select_n) n = 0;
    always @(posedge pins_i.flash_select_n) line_o = ~line_o;
    // data changes after sck falls, msb first, after the 8 opcode bits
    always @(negedge pins_i.sck) begin
        n = n + 1;
        if (n >= 8 && n < 16) line_o[1] = data_i[15-n];
    end
endmodule // sfc_flash_model

/* File: verif/serial_flash_controller_test.sv */
// Purpose: self-checking bench for the serial flash controller
// Assumes: 25 MHz clock, divider zero gives a 320 ns flash clock
// Notes: one hand-written task per scenario
module serial_flash_controller_test;
    timeunit 1ns;
    timeprecision 1ns;
    import sfc_pkg::*;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [5:0] avs_address_i = 6'h00;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0000_0000;
    logic [31:0] mm_address_i = 32'h1000_0000;
    logic mm_read_i = 1'b0;
    logic [7:0] flash_line_i, model_line;
    logic [31:0] avs_readdata_o, mm_readdata_o, q;
    logic avs_waitrequest_o, mm_waitrequest_o, dma_req_o, match_irq_o;
    pins_s flash_o;
    int failures = 0;
    int check_count = 0;
    always #20 clk_i = ~clk_i;
    assign flash_line_i = (flash_o.line_out & flash_o.line_oe)
        | (model_line & ~flash_o.line_oe);
    serial_flash_controller i_serial_flash_controller (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .mm_address_i(mm_address_i),
        .mm_read_i(mm_read_i), .mm_readdata_o(mm_readdata_o),
        .mm_waitrequest_o(mm_waitrequest_o), .flash_line_i(flash_line_i),
        .flash_o(flash_o), .dma_req_o(dma_req_o), .match_irq_o(match_irq_o));
    sfc_flash_model i_sfc_flash_model (.pins_i(flash_o), .data_i(8'hA5),
        .line_o(model_line));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge clk_i);
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_write_i <= w;
        avs_read_i <= !w;
        do begin
            @(posedge clk_i);
            n++;
        end while (avs_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i <= 1'b0;
    endtask
    task automatic t_regs();
        acc(1'b0, CR_OFS, 32'h0000_0000);
        chk(q, 32'h0000_0000);
        acc(1'b1, DCR_OFS, 32'h0000_001F);
        acc(1'b0, DCR_OFS, 32'h0000_0000);
        chk(q, 32'h0000_001F);
        acc(1'b0, 6'h3C, 32'h0000_0000);
        chk(q, 32'h0000_0000);
    endtask
    task automatic t_read();
        int n = 0;
        acc(1'b1, CCR_OFS, 32'h0500_0103);
        acc(1'b1, DLR_OFS, 32'h0000_0001);
        acc(1'b1, CR_OFS, 32'h0000_0001);
        acc(1'b1, AR_OFS, 32'h0000_0000);
        do begin
            acc(1'b0, SR_OFS, 32'h0000_0000);
            n++;
        end while (q[0] !== 1'b0 && n < 200);
        if (n >= 200) failures++;
        chk({26'h0, q[13:8]}, 32'h0000_0001);
        acc(1'b0, DR_OFS, 32'h0000_0000);
        chk({24'h0, q[7:0]}, 32'h0000_00A5);
    endtask
    task automatic t_off();
        acc(1'b1, CR_OFS, 32'h0000_0000);
        acc(1'b1, AR_OFS, 32'h0000_0000);
        repeat (20) @(posedge clk_i);
        chk({31'h0, flash_o.flash_select_n}, 32'h0000_0001);
    endtask
    task automatic t_poll(input logic [31:0] mk, input logic [31:0] ma,
                          input logic hit);
        int n = 0;
        acc(1'b1, CR_OFS, 32'h0000_0000);
        acc(1'b1, SR_OFS, 32'h0000_0002);
        acc(1'b1, PSMK_OFS, mk);
        acc(1'b1, PSMA_OFS, ma);
        acc(1'b1, PIR_OFS, 32'h0000_0010);
        acc(1'b1, CCR_OFS, 32'h0900_0105);
        acc(1'b1, DLR_OFS, 32'h0000_0008);
        acc(1'b1, CR_OFS, 32'h0000_0023);
        while (match_irq_o !== 1'b1 && n < 1200) begin
            @(posedge clk_i);
            n++;
        end
        chk({31'h0, match_irq_o}, {31'h0, hit});
        acc(1'b0, SR_OFS, 32'h0000_0000);
        chk({31'h0, q[1]}, {31'h0, hit});
        acc(1'b0, DR_OFS, 32'h0000_0000);
        chk({24'h0, q[7:0]}, 32'h0000_00A5);
        repeat (100) @(posedge clk_i);
        if (hit) chk({31'h0, flash_o.flash_select_n}, 32'h1);
    endtask
    task automatic t_mm();
        int n = 0;
        @(posedge clk_i);
        mm_read_i <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (mm_waitrequest_o !== 1'b0 && n < 50);
        if (n >= 50) failures++;
        chk(mm_readdata_o, 32'h0000_0000);
        mm_read_i <= 1'b0;
    endtask
    task automatic summarize();
        if (failures == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk_i);
        arst_n_i <= 1'b1;
        t_regs();
        t_read();
        t_off();
        t_poll(32'h0000_00FF, 32'h0000_005A, 1'b0);
        t_poll(32'h0000_000F, 32'h0000_0005, 1'b1);
        t_mm();
        summarize();
    end
    // the run needs about 2000 cycles; the limit leaves wide margin
    initial begin
        #800000;
        failures++;
        summarize();
    end
endmodule // serial_flash_controller_test
